// File: hdl/pfs_pkg.sv
package pfs_pkg;

  // Register byte offsets
  localparam logic [7:0] PFS_CTRL_OFS = 8'h00;
  localparam logic [7:0] PFS_FLOOR_OFS = 8'h04;
  localparam logic [7:0] PFS_CEIL_OFS = 8'h08;
  localparam logic [7:0] PFS_INIT_RAMP_OFS = 8'h0c;
  localparam logic [7:0] PFS_FILL_RATE_OFS = 8'h10;
  localparam logic [7:0] PFS_FILLED_SP_OFS = 8'h14;
  localparam logic [7:0] PFS_FB_MIN_OFS = 8'h18;
  localparam logic [7:0] PFS_REF_MAX_OFS = 8'h1c;
  localparam logic [7:0] PFS_SP1_OFS = 8'h20;
  localparam logic [7:0] PFS_SP2_OFS = 8'h24;
  localparam logic [7:0] PFS_MIN_FREQ_OFS = 8'h28;
  localparam logic [7:0] PFS_PID_FREQ_OFS = 8'h2c;
  localparam logic [7:0] PFS_STATUS_OFS = 8'h30;
  localparam logic [7:0] PFS_IRQ_STAT_OFS = 8'h34;
  localparam logic [7:0] PFS_IRQ_MASK_OFS = 8'h38;
  localparam logic [7:0] PFS_NORM_RAMP_OFS = 8'h3c;

  // Control register fields
  localparam int PFS_CTRL_CLOSED = 0;
  localparam int PFS_CTRL_NORMAL = 1;
  localparam int PFS_CTRL_SP2 = 2;
  localparam int PFS_CTRL_UND_SIG = 4;
  localparam int PFS_CTRL_UND_REL = 5;
  localparam int PFS_CTRL_OVR_SIG = 6;
  localparam int PFS_CTRL_OVR_REL = 7;
  localparam int PFS_CTRL_W = 8;

  // Interrupt status bits
  localparam int PFS_IRQ_UNDER = 0;
  localparam int PFS_IRQ_OVER = 1;
  localparam int PFS_IRQ_FILLED = 2;
  localparam int PFS_IRQ_W = 3;

  // Value limits, thousandths of a process unit (initial ramp limit excepted), and scale factors
  localparam logic signed [31:0] PFS_LIM_MIN = -32'sd999999999;
  localparam logic signed [31:0] PFS_LIM_MAX = 32'sd999999999;
  localparam logic [31:0] PFS_RATE_MAX = 32'd999999999;
  localparam logic [11:0] PFS_INIT_RAMP_MAX = 12'd3600;
  localparam logic [31:0] PFS_MILLI = 32'd1000;
  localparam logic signed [31:0] PFS_CENTI_TO_MILLI = 32'sd10;

  // Reset values
  localparam logic signed [31:0] PFS_REF_MAX_RST = 32'sd100000;
  localparam logic [11:0] PFS_NORM_RAMP_RST = 12'd100;

  // Timing
  localparam int PFS_CLK_MHZ = 100;
  localparam int PFS_FLASH_MS = 250;
  localparam int PFS_TICK_MS = 1;
  localparam int PFS_FLASH_CYC = PFS_FLASH_MS * 1000 * PFS_CLK_MHZ;
  localparam int PFS_TICK_CYC = PFS_TICK_MS * 1000 * PFS_CLK_MHZ;

  typedef enum logic [2:0] {
    PFS_IDLE, PFS_WAIT_MIN, PFS_WAIT_PID, PFS_FILL, PFS_NORMAL
  } pfs_state_t;

endpackage

// File: hdl/pfs_supervisor.sv
// Our own choices: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
module pfs_supervisor
  import pfs_pkg::*;
#(
  parameter int FLASH_CYC = PFS_FLASH_CYC,
  parameter int TICK_CYC = PFS_TICK_CYC
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] s_axi_awaddr_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  output logic [1:0] s_axi_bresp_o,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  input wire logic [31:0] s_axi_araddr_i,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  input wire logic run_cmd_i,
  input wire logic at_reference_i,
  input wire logic [15:0] out_freq_i,
  input wire logic signed [31:0] feedback_i,
  output logic feedback_under_alarm_o,
  output logic feedback_over_alarm_o,
  output logic under_signal_o,
  output logic under_relay_o,
  output logic over_signal_o,
  output logic over_relay_o,
  output logic [11:0] ramp_time_o,
  output logic init_ramp_active_o,
  output logic init_ramp_off_o,
  output logic fill_active_o,
  output logic pid_enable_o,
  output logic signed [31:0] setpoint_o,
  output logic irq_o
);

  localparam logic [1:0] RESP_OK = 2'b00;
  localparam logic [1:0] RESP_ERR = 2'b10;

  function automatic logic signed [31:0] clamp(input logic signed [31:0] v,
                                               input logic signed [31:0] lo,
                                               input logic signed [31:0] hi);
    clamp = (v < lo) ? lo : ((v > hi) ? hi : v);
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      old[i*8 +: 8] = strb[i] ? nw[i*8 +: 8] : old[i*8 +: 8];
    end
    merge = old;
  endfunction

  function automatic logic mapped(input logic [7:0] a);
    mapped = (a[1:0] == 2'b00) && (a <= PFS_NORM_RAMP_OFS);
  endfunction

  // Registers
  logic [PFS_CTRL_W-1:0] ctrl_q;
  logic signed [31:0] floor_q;
  logic signed [31:0] ceil_q;
  logic [11:0] init_ramp_q;
  logic [11:0] norm_ramp_q;
  logic [31:0] fill_rate_q;
  logic signed [31:0] filled_sp_q;
  logic signed [31:0] fb_min_q;
  logic signed [31:0] ref_max_q;
  logic signed [31:0] sp1_q;
  logic signed [31:0] sp2_q;
  logic [15:0] min_freq_q;
  logic [15:0] pid_freq_q;
  logic [PFS_IRQ_W-1:0] irq_stat_q;
  logic [PFS_IRQ_W-1:0] irq_mask_q;

  // Bus slave state
  logic aw_hold_q;
  logic w_hold_q;
  logic [7:0] awaddr_q;
  logic [31:0] wdata_q;
  logic [3:0] wstrb_q;
  wire aw_take = s_axi_awvalid_i & s_axi_awready_o;
  wire w_take = s_axi_wvalid_i & s_axi_wready_o;
  wire wr_do = aw_hold_q & w_hold_q & ~s_axi_bvalid_o;
  wire aw_hold_d = (aw_hold_q & ~wr_do) | aw_take;
  wire w_hold_d = (w_hold_q & ~wr_do) | w_take;
  wire rd_take = s_axi_arvalid_i & s_axi_arready_o;
  wire rvalid_d = (s_axi_rvalid_o & ~s_axi_rready_i) | rd_take;
  wire [7:0] rd_addr = s_axi_araddr_i[7:0];
  wire rd_ok = mapped(rd_addr) && (s_axi_araddr_i[31:8] == 24'h000000);
  wire wr_ok = mapped(awaddr_q);

  function automatic logic wr_hit(input logic [7:0] ofs, input logic [7:0] a, input logic go);
    wr_hit = go && (a == ofs);
  endfunction

  wire [31:0] wr_word = wdata_q;

  // State and event signals
  pfs_state_t state_q;
  pfs_state_t state_d;
  logic [31:0] flash_cnt_q;
  logic flash_q;
  logic [31:0] tick_cnt_q;
  logic tick_q;
  logic [31:0] frac_q;
  logic signed [31:0] fill_sp_q;
  logic fill_up_q;
  logic under_q;
  logic over_q;

  wire at_min = out_freq_i >= min_freq_q;
  wire at_pid = out_freq_i >= pid_freq_q;
  wire fill_allowed = ctrl_q[PFS_CTRL_CLOSED] && ctrl_q[PFS_CTRL_NORMAL] &&
                      (fill_rate_q != 32'h00000000);
  wire supervise = run_cmd_i & at_reference_i;
  wire under_raw = supervise && (feedback_i < floor_q);
  wire over_raw = supervise && (feedback_i > ceil_q);
  wire signed [31:0] filled_milli = filled_sp_q * PFS_CENTI_TO_MILLI;
  wire signed [31:0] fill_target = clamp(filled_milli, fb_min_q, ref_max_q);
  wire filled = fill_up_q ? (feedback_i >= fill_target) :
                            (feedback_i <= fill_target);
  wire signed [31:0] oper_sp = ctrl_q[PFS_CTRL_SP2] ? sp2_q : sp1_q;
  wire [31:0] frac_sum = frac_q + fill_rate_q;
  wire signed [31:0] step = $signed(frac_sum / PFS_MILLI);
  wire [31:0] frac_next = frac_sum % PFS_MILLI;
  wire signed [31:0] sp_up = clamp(fill_sp_q + step, PFS_LIM_MIN, fill_target);
  wire signed [31:0] sp_dn = clamp(fill_sp_q - step, fill_target, PFS_LIM_MAX);
  wire fill_done_evt = (state_q == PFS_FILL) && filled;
  wire [PFS_IRQ_W-1:0] irq_evt = {fill_done_evt, over_raw & ~over_q, under_raw & ~under_q};
  wire [PFS_IRQ_W-1:0] irq_clr = wr_hit(PFS_IRQ_STAT_OFS, awaddr_q, wr_do) ?
                                 wdata_q[PFS_IRQ_W-1:0] : '0;
  wire init_ramp_on = (init_ramp_q != 12'h000) && run_cmd_i && !at_min;

  // Fill sequence
  always_comb begin
    state_d = state_q;
    case (state_q)
      PFS_IDLE: if (run_cmd_i && fill_allowed) state_d = PFS_WAIT_MIN;
      PFS_WAIT_MIN: if (at_min) state_d = PFS_WAIT_PID;
      PFS_WAIT_PID: if (at_pid) state_d = PFS_FILL;
      PFS_FILL: if (filled) state_d = PFS_NORMAL;
      PFS_NORMAL: state_d = PFS_NORMAL;
      default: state_d = PFS_IDLE;
    endcase
    if (!run_cmd_i) begin
      state_d = PFS_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_q <= PFS_IDLE;
      fill_sp_q <= '0;
      frac_q <= '0;
      fill_up_q <= 1'b1;
    end else begin
      state_q <= state_d;
      if (state_q == PFS_WAIT_MIN && at_min) begin
        fill_sp_q <= feedback_i;
        fill_up_q <= feedback_i <= fill_target;
        frac_q <= '0;
      end else if (state_q == PFS_FILL && tick_q) begin
        fill_sp_q <= fill_up_q ? sp_up : sp_dn;
        frac_q <= frac_next;
      end
    end
  end

  // Flash and millisecond tick dividers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      flash_cnt_q <= '0;
      flash_q <= 1'b0;
      tick_cnt_q <= '0;
      tick_q <= 1'b0;
    end else begin
      flash_cnt_q <= (flash_cnt_q == 32'(FLASH_CYC - 1)) ? '0 : flash_cnt_q + 32'd1;
      if (flash_cnt_q == 32'(FLASH_CYC - 1)) begin
        flash_q <= ~flash_q;
      end
      tick_cnt_q <= (tick_cnt_q == 32'(TICK_CYC - 1)) ? '0 : tick_cnt_q + 32'd1;
      tick_q <= tick_cnt_q == 32'(TICK_CYC - 1);
    end
  end

  // Warning and drive outputs
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      under_q <= 1'b0;
      over_q <= 1'b0;
      feedback_under_alarm_o <= 1'b0;
      feedback_over_alarm_o <= 1'b0;
      under_signal_o <= 1'b0;
      under_relay_o <= 1'b0;
      over_signal_o <= 1'b0;
      over_relay_o <= 1'b0;
      ramp_time_o <= PFS_NORM_RAMP_RST;
      init_ramp_active_o <= 1'b0;
      init_ramp_off_o <= 1'b1;
      fill_active_o <= 1'b0;
      pid_enable_o <= 1'b0;
      setpoint_o <= '0;
      irq_o <= 1'b0;
    end else begin
      under_q <= under_raw;
      over_q <= over_raw;
      feedback_under_alarm_o <= under_raw & flash_q;
      feedback_over_alarm_o <= over_raw & flash_q;
      under_signal_o <= under_raw & ctrl_q[PFS_CTRL_UND_SIG];
      under_relay_o <= under_raw & ctrl_q[PFS_CTRL_UND_REL];
      over_signal_o <= over_raw & ctrl_q[PFS_CTRL_OVR_SIG];
      over_relay_o <= over_raw & ctrl_q[PFS_CTRL_OVR_REL];
      ramp_time_o <= init_ramp_on ? init_ramp_q : norm_ramp_q;
      init_ramp_active_o <= init_ramp_on;
      init_ramp_off_o <= init_ramp_q == 12'h000;
      fill_active_o <= state_q == PFS_FILL;
      pid_enable_o <= run_cmd_i && ctrl_q[PFS_CTRL_CLOSED] &&
                      (state_q == PFS_FILL || state_q == PFS_NORMAL || !fill_allowed);
      setpoint_o <= (state_q == PFS_FILL) ? fill_sp_q : oper_sp;
      irq_o <= |(irq_stat_q & irq_mask_q);
    end
  end

  // Bus write side
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= '0;
      wstrb_q <= '0;
      s_axi_awready_o <= 1'b0;
      s_axi_wready_o <= 1'b0;
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o <= RESP_OK;
    end else begin
      aw_hold_q <= aw_hold_d;
      w_hold_q <= w_hold_d;
      s_axi_awready_o <= ~aw_hold_d;
      s_axi_wready_o <= ~w_hold_d;
      if (aw_take) begin
        awaddr_q <= (s_axi_awaddr_i[31:8] == 24'h000000) ? s_axi_awaddr_i[7:0] : 8'hff;
      end
      if (w_take) begin
        wdata_q <= s_axi_wdata_i;
        wstrb_q <= s_axi_wstrb_i;
      end
      if (wr_do) begin
        s_axi_bvalid_o <= 1'b1;
        s_axi_bresp_o <= wr_ok ? RESP_OK : RESP_ERR;
      end else if (s_axi_bready_i) begin
        s_axi_bvalid_o <= 1'b0;
      end
    end
  end

  // Register file, byte lanes merged before any clamp
  wire [31:0] m_ctrl = merge({24'h000000, ctrl_q}, wr_word, wstrb_q);
  wire [31:0] m_floor = merge(floor_q, wr_word, wstrb_q);
  wire [31:0] m_ceil = merge(ceil_q, wr_word, wstrb_q);
  wire [31:0] m_init = merge({20'h00000, init_ramp_q}, wr_word, wstrb_q);
  wire [31:0] m_norm = merge({20'h00000, norm_ramp_q}, wr_word, wstrb_q);
  wire [31:0] m_rate = merge(fill_rate_q, wr_word, wstrb_q);
  wire [31:0] m_minf = merge({16'h0000, min_freq_q}, wr_word, wstrb_q);
  wire [31:0] m_pidf = merge({16'h0000, pid_freq_q}, wr_word, wstrb_q);
  wire [31:0] m_mask = merge({29'h00000000, irq_mask_q}, wr_word, wstrb_q);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= '0;
      floor_q <= PFS_LIM_MIN;
      ceil_q <= PFS_LIM_MAX;
      init_ramp_q <= '0;
      norm_ramp_q <= PFS_NORM_RAMP_RST;
      fill_rate_q <= '0;
      filled_sp_q <= '0;
      fb_min_q <= '0;
      ref_max_q <= PFS_REF_MAX_RST;
      sp1_q <= '0;
      sp2_q <= '0;
      min_freq_q <= '0;
      pid_freq_q <= '0;
      irq_mask_q <= '0;
      irq_stat_q <= '0;
    end else begin
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
      if (wr_hit(PFS_CTRL_OFS, awaddr_q, wr_do))
        ctrl_q <= m_ctrl[PFS_CTRL_W-1:0];
      if (wr_hit(PFS_FLOOR_OFS, awaddr_q, wr_do))
        floor_q <= clamp($signed(m_floor), PFS_LIM_MIN, ceil_q);
      if (wr_hit(PFS_CEIL_OFS, awaddr_q, wr_do))
        ceil_q <= clamp($signed(m_ceil), floor_q, PFS_LIM_MAX);
      if (wr_hit(PFS_INIT_RAMP_OFS, awaddr_q, wr_do))
        init_ramp_q <= (m_init > 32'(PFS_INIT_RAMP_MAX)) ? PFS_INIT_RAMP_MAX : m_init[11:0];
      if (wr_hit(PFS_NORM_RAMP_OFS, awaddr_q, wr_do))
        norm_ramp_q <= m_norm[11:0];
      if (wr_hit(PFS_FILL_RATE_OFS, awaddr_q, wr_do))
        fill_rate_q <= (m_rate > PFS_RATE_MAX) ? PFS_RATE_MAX : m_rate;
      if (wr_hit(PFS_FILLED_SP_OFS, awaddr_q, wr_do))
        filled_sp_q <= merge(filled_sp_q, wr_word, wstrb_q);
      if (wr_hit(PFS_FB_MIN_OFS, awaddr_q, wr_do))
        fb_min_q <= merge(fb_min_q, wr_word, wstrb_q);
      if (wr_hit(PFS_REF_MAX_OFS, awaddr_q, wr_do))
        ref_max_q <= merge(ref_max_q, wr_word, wstrb_q);
      if (wr_hit(PFS_SP1_OFS, awaddr_q, wr_do))
        sp1_q <= merge(sp1_q, wr_word, wstrb_q);
      if (wr_hit(PFS_SP2_OFS, awaddr_q, wr_do))
        sp2_q <= merge(sp2_q, wr_word, wstrb_q);
      if (wr_hit(PFS_MIN_FREQ_OFS, awaddr_q, wr_do))
        min_freq_q <= m_minf[15:0];
      if (wr_hit(PFS_PID_FREQ_OFS, awaddr_q, wr_do))
        pid_freq_q <= m_pidf[15:0];
      if (wr_hit(PFS_IRQ_MASK_OFS, awaddr_q, wr_do))
        irq_mask_q <= m_mask[PFS_IRQ_W-1:0];
    end
  end

  // Bus read side
  wire [31:0] status_word = {24'h000000, under_q, over_q, fill_allowed,
                             init_ramp_on, 1'b0, state_q};
  logic [31:0] rd_word;
  always_comb begin
    case (rd_addr)
      PFS_CTRL_OFS: rd_word = {24'h000000, ctrl_q};
      PFS_FLOOR_OFS: rd_word = floor_q;
      PFS_CEIL_OFS: rd_word = ceil_q;
      PFS_INIT_RAMP_OFS: rd_word = {20'h00000, init_ramp_q};
      PFS_FILL_RATE_OFS: rd_word = fill_rate_q;
      PFS_FILLED_SP_OFS: rd_word = filled_sp_q;
      PFS_FB_MIN_OFS: rd_word = fb_min_q;
      PFS_REF_MAX_OFS: rd_word = ref_max_q;
      PFS_SP1_OFS: rd_word = sp1_q;
      PFS_SP2_OFS: rd_word = sp2_q;
      PFS_MIN_FREQ_OFS: rd_word = {16'h0000, min_freq_q};
      PFS_PID_FREQ_OFS: rd_word = {16'h0000, pid_freq_q};
      PFS_STATUS_OFS: rd_word = status_word;
      PFS_IRQ_STAT_OFS: rd_word = {29'h00000000, irq_stat_q};
      PFS_IRQ_MASK_OFS: rd_word = {29'h00000000, irq_mask_q};
      PFS_NORM_RAMP_OFS: rd_word = {20'h00000, norm_ramp_q};
      default: rd_word = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_axi_arready_o <= 1'b0;
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o <= '0;
      s_axi_rresp_o <= RESP_OK;
    end else begin
      s_axi_arready_o <= ~rvalid_d;
      s_axi_rvalid_o <= rvalid_d;
      if (rd_take) begin
        s_axi_rdata_o <= rd_ok ? rd_word : 32'h00000000;
        s_axi_rresp_o <= rd_ok ? RESP_OK : RESP_ERR;
      end
    end
  end

endmodule

// File: tb/pfs_supervisor_props.sv
`timescale 1ns/1ps
module pfs_supervisor_props (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_cmd_i,
  input wire logic at_reference_i,
  input wire logic feedback_under_alarm_o,
  input wire logic feedback_over_alarm_o,
  input wire logic under_signal_o,
  input wire logic over_signal_o,
  input wire logic [11:0] ramp_time_o,
  input wire logic init_ramp_active_o,
  input wire logic init_ramp_off_o,
  input wire logic fill_active_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  property p_und_sup; feedback_under_alarm_o |-> $past(run_cmd_i && at_reference_i); endproperty
  a_und_sup: assert property (p_und_sup) else $error("under alarm unsupervised");
  property p_ovr_sup; feedback_over_alarm_o |-> $past(run_cmd_i && at_reference_i); endproperty
  a_ovr_sup: assert property (p_ovr_sup) else $error("over alarm unsupervised");
  property p_sig_sup; under_signal_o || over_signal_o |-> $past(at_reference_i); endproperty
  a_sig_sup: assert property (p_sig_sup) else $error("warning output unsupervised");
  property p_excl; !(under_signal_o && over_signal_o); endproperty
  a_excl: assert property (p_excl) else $error("under and over together");
  property p_off; init_ramp_off_o |-> !init_ramp_active_o; endproperty
  a_off: assert property (p_off) else $error("initial ramp active while off");
  property p_rmax; init_ramp_active_o |-> ramp_time_o <= 12'he10; endproperty
  a_rmax: assert property (p_rmax) else $error("ramp time above limit");
  property p_stop; !run_cmd_i [*3] |-> !fill_active_o; endproperty
  a_stop: assert property (p_stop) else $error("fill survives stop");
  property p_rise; $rose(fill_active_o) |-> $past(run_cmd_i, 2); endproperty
  a_rise: assert property (p_rise) else $error("fill without start");
  c_fill: cover property (fill_active_o);
  c_under: cover property (under_signal_o);
  c_init: cover property ($fell(init_ramp_active_o));
endmodule
bind pfs_supervisor pfs_supervisor_props u_pfs_supervisor_props (
  .clk_i(clk_i), .rst_i(rst_i), .run_cmd_i(run_cmd_i), .at_reference_i(at_reference_i),
  .feedback_under_alarm_o(feedback_under_alarm_o),
  .feedback_over_alarm_o(feedback_over_alarm_o),
  .under_signal_o(under_signal_o), .over_signal_o(over_signal_o), .ramp_time_o(ramp_time_o),
  .init_ramp_active_o(init_ramp_active_o), .init_ramp_off_o(init_ramp_off_o),
  .fill_active_o(fill_active_o));

// File: tb/pfs_drive_model.sv
`timescale 1ns/1ps
module pfs_drive_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic run_cmd_i,
  input wire logic [15:0] ref_freq_i,
  input wire logic signed [31:0] press_tgt_i,
  input wire logic signed [31:0] press_step_i,
  output logic at_reference_o,
  output logic [15:0] out_freq_o,
  output logic signed [31:0] feedback_o
);
  assign at_reference_o = run_cmd_i && (out_freq_o == ref_freq_i);
  // Speed moves one step a cycle, pressure by the given step
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      out_freq_o <= 16'h0000;
      feedback_o <= 32'sh0;
    end else begin
      if (run_cmd_i && out_freq_o < ref_freq_i) begin
        out_freq_o <= out_freq_o + 16'h0001;
      end else if (out_freq_o != 16'h0000 && !at_reference_o) begin
        out_freq_o <= out_freq_o - 16'h0001;
      end
      if (press_tgt_i - feedback_o > press_step_i) begin
        feedback_o <= feedback_o + press_step_i;
      end else if (feedback_o - press_tgt_i > press_step_i) begin
        feedback_o <= feedback_o - press_step_i;
      end else begin
        feedback_o <= press_tgt_i;
      end
    end
  end
endmodule

// File: tb/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import pfs_pkg::*;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic run = 1'h0, awready, wready, bvalid, arready, rvalid, at_ref, irq;
  logic und_a, ovr_a, und_s, und_r, ovr_s, ovr_r, ir_act, ir_off, fill, pid_en;
  logic [1:0] bresp, rresp;
  logic [11:0] ramp_t;
  logic [15:0] ofreq, ref_freq = 16'h012c, lfsr = 16'h5e19;
  logic signed [31:0] fb, sp, p_tgt = '0, p_step = 32'sh100000, v, sp0;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int mismatches = 0, cmp_count = 0, n;
  pfs_supervisor #(.FLASH_CYC(8), .TICK_CYC(4)) u_pfs_supervisor (
    .clk_i(clk_i), .rst_i(rst_i), .s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid),
    .s_axi_awready_o(awready), .s_axi_wdata_i(wdata), .s_axi_wstrb_i(4'hf),
    .s_axi_wvalid_i(wvalid), .s_axi_wready_o(wready), .s_axi_bresp_o(bresp),
    .s_axi_bvalid_o(bvalid), .s_axi_bready_i(bready), .s_axi_araddr_i(araddr),
    .s_axi_arvalid_i(arvalid), .s_axi_arready_o(arready), .s_axi_rdata_o(rdata),
    .s_axi_rresp_o(rresp), .s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready),
    .run_cmd_i(run), .at_reference_i(at_ref), .out_freq_i(ofreq), .feedback_i(fb),
    .feedback_under_alarm_o(und_a), .feedback_over_alarm_o(ovr_a), .under_signal_o(und_s),
    .under_relay_o(und_r), .over_signal_o(ovr_s), .over_relay_o(ovr_r), .ramp_time_o(ramp_t),
    .init_ramp_active_o(ir_act), .init_ramp_off_o(ir_off), .fill_active_o(fill),
    .pid_enable_o(pid_en), .setpoint_o(sp), .irq_o(irq));
  pfs_drive_model u_pfs_drive_model (
    .clk_i(clk_i), .rst_i(rst_i), .run_cmd_i(run), .ref_freq_i(ref_freq),
    .press_tgt_i(p_tgt), .press_step_i(p_step), .at_reference_o(at_ref),
    .out_freq_o(ofreq), .feedback_o(fb));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic cmp_rd(input logic [33:0] g, input logic [33:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic cmp_b(input logic [1:0] g, input logic [1:0] e);
    cmp_rd({32'h0, g}, {32'h0, e});
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_rd({2'h0, g}, {2'h0, e});
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    bq.push_back(r);
    awaddr <= {24'h0, a};
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      if (bready && bvalid) bready <= 1'h0;
    end while (awvalid || wvalid || bready);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r = 2'h0);
    rq.push_back({r, d});
    araddr <= {24'h0, a};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge clk_i);
      if (arvalid && arready) arvalid <= 1'h0;
      if (rready && rvalid) rready <= 1'h0;
    end while (arvalid || rready);
  endtask
  always @(posedge clk_i) begin
    if (rvalid && rready) cmp_rd({rresp, rdata}, rq.pop_front());
    if (bvalid && bready) cmp_b(bresp, bq.pop_front());
  end
  task automatic go;
    run <= 1'h1;
    for (n = 0; n < 2000 && !at_ref; n++) @(posedge clk_i);
    repeat (3) @(posedge clk_i);
  endtask
  task automatic halt;
    run <= 1'h0;
    repeat (310) @(posedge clk_i);
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #500000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (8) @(posedge clk_i);
    rst_i <= 1'h0;
    @(posedge clk_i);
    rd(PFS_FLOOR_OFS, 32'hc4653601);
    rd(PFS_CEIL_OFS, 32'h3b9ac9ff);
    rd(PFS_INIT_RAMP_OFS, 32'h0);
    rd(PFS_FILL_RATE_OFS, 32'h0);
    rd(PFS_FILLED_SP_OFS, 32'h0);
    chk1(ir_off, 1'h1);
    rd(8'h40, 32'h0, 2'h2);
    wr(8'h40, 32'h1, 2'h2);
    wr(PFS_FLOOR_OFS, 32'h3e8);
    wr(PFS_CEIL_OFS, 32'h1f4);
    rd(PFS_CEIL_OFS, 32'h3e8);
    wr(PFS_CEIL_OFS, 32'h1388);
    wr(PFS_FLOOR_OFS, 32'h2710);
    rd(PFS_FLOOR_OFS, 32'h1388);
    wr(PFS_FLOOR_OFS, 32'h3e8);
    wr(PFS_INIT_RAMP_OFS, 32'h1000);
    rd(PFS_INIT_RAMP_OFS, 32'he10);
    wr(PFS_FILL_RATE_OFS, 32'hffffffff);
    rd(PFS_FILL_RATE_OFS, 32'h3b9ac9ff);
    $display("limits done");
    wr(PFS_CTRL_OFS, 32'hf0);
    p_tgt <= 32'shfffffe0c;
    repeat (4) @(posedge clk_i);
    chk1(und_s, 1'h0);
    go();
    chk1(und_s, 1'h1);
    chk1(und_r, 1'h1);
    n = 0;
    repeat (32) begin
      @(posedge clk_i);
      n += und_a;
    end
    chk(32'(n), 32'h10);
    p_tgt <= 32'sh1770;
    repeat (4) @(posedge clk_i);
    chk1(ovr_s, 1'h1);
    chk1(ovr_r, 1'h1);
    chk1(und_s, 1'h0);
    n = 0;
    repeat (32) begin
      @(posedge clk_i);
      n += ovr_a;
    end
    chk(32'(n), 32'h10);
    rd(PFS_IRQ_STAT_OFS, 32'h3);
    chk1(irq, 1'h0);
    wr(PFS_IRQ_MASK_OFS, 32'h3);
    repeat (2) @(posedge clk_i);
    chk1(irq, 1'h1);
    run <= 1'h0;
    repeat (3) @(posedge clk_i);
    chk1(ovr_s, 1'h0);
    halt();
    go();
    for (int i = 0; i < 12; i++) begin
      lfsr = nxt(lfsr);
      v = $signed({16'h0, lfsr}) % 32'sh1b58 - 32'sh3e8;
      p_tgt <= v;
      repeat (4) @(posedge clk_i);
      chk1(und_s, v < 32'sh3e8);
      chk1(ovr_s, v > 32'sh1388);
    end
    p_tgt <= 32'sh0;
    halt();
    wr(PFS_IRQ_STAT_OFS, 32'h7);
    rd(PFS_IRQ_STAT_OFS, 32'h0);
    chk1(irq, 1'h0);
    $display("alarms done");
    wr(PFS_INIT_RAMP_OFS, 32'h32);
    wr(PFS_MIN_FREQ_OFS, 32'h64);
    chk1(ir_off, 1'h0);
    run <= 1'h1;
    repeat (20) @(posedge clk_i);
    chk1(ir_act, 1'h1);
    chk(32'(ramp_t), 32'h32);
    go();
    chk1(ir_act, 1'h0);
    chk(32'(ramp_t), 32'h64);
    halt();
    wr(PFS_INIT_RAMP_OFS, 32'h0);
    run <= 1'h1;
    repeat (20) @(posedge clk_i);
    chk1(ir_off, 1'h1);
    chk1(ir_act, 1'h0);
    halt();
    $display("initial ramp done");
    p_step <= 32'sh1;
    wr(PFS_CTRL_OFS, 32'h7);
    wr(PFS_FILL_RATE_OFS, 32'hfa0);
    wr(PFS_FILLED_SP_OFS, 32'h1e);
    wr(PFS_SP2_OFS, 32'h1b58);
    wr(PFS_PID_FREQ_OFS, 32'hc8);
    wr(PFS_IRQ_MASK_OFS, 32'h4);
    run <= 1'h1;
    repeat (150) @(posedge clk_i);
    chk1(fill, 1'h0);
    chk1(pid_en, 1'h0);
    repeat (60) @(posedge clk_i);
    chk1(fill, 1'h1);
    sp0 = sp;
    repeat (40) @(posedge clk_i);
    chk1(sp - sp0 >= 32'sh24 && sp - sp0 <= 32'sh2c, 1'h1);
    repeat (400) @(posedge clk_i);
    chk(sp, 32'h12c);
    p_tgt <= 32'sh12c;
    repeat (150) @(posedge clk_i);
    chk1(fill, 1'h1);
    repeat (200) @(posedge clk_i);
    chk1(fill, 1'h0);
    chk(sp, 32'h1b58);
    chk1(pid_en, 1'h1);
    chk1(irq, 1'h1);
    p_step <= 32'sh100000;
    p_tgt <= 32'sh0;
    halt();
    run <= 1'h1;
    repeat (260) @(posedge clk_i);
    chk1(fill, 1'h1);
    run <= 1'h0;
    repeat (4) @(posedge clk_i);
    chk1(fill, 1'h0);
    halt();
    wr(PFS_CTRL_OFS, 32'h5);
    go();
    chk1(fill, 1'h0);
    chk(sp, 32'h1b58);
    halt();
    $display("fill done");
    print_verdict();
  end
endmodule
